/* File: rtl/vfid_pkg.sv */
// Purpose: constants for the vector feature identification register
// Assumes: one 64-bit read-only value, system-register style access
// Notes:   field positions are lsb positions of 4-bit fields
package vfid_pkg;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int unsigned FIELD_W              = 4;
    localparam int unsigned REG_W                = 64;
    localparam int unsigned DOUBLE_MATMUL_LSB    = 56;
    localparam int unsigned SINGLE_MATMUL_LSB    = 52;
    localparam int unsigned BYTE_INT_MATMUL_LSB  = 44;
    localparam int unsigned BLOCK_CIPHER_LSB     = 40;
    localparam int unsigned KECCAK_HASH_LSB      = 32;
    localparam int unsigned BRAIN_FLOAT_LSB      = 20;
    localparam int unsigned BIT_PERMUTE_LSB      = 16;
    localparam int unsigned CIPHER_ROUND_LSB     = 4;
    localparam int unsigned BASE_VERSION_LSB     = 0;

    // ------------------------------------------------------------
    // field values
    // ------------------------------------------------------------
    localparam logic [3:0] DOUBLE_MATMUL_VAL     = 4'h0;
    localparam logic [3:0] SINGLE_MATMUL_VAL     = 4'h0;
    localparam logic [3:0] BYTE_INT_MATMUL_VAL   = 4'h1;
    localparam logic [3:0] BLOCK_CIPHER_ON_VAL   = 4'h1;
    localparam logic [3:0] KECCAK_HASH_ON_VAL    = 4'h1;
    localparam logic [3:0] BRAIN_FLOAT_VAL       = 4'h1;
    localparam logic [3:0] BIT_PERMUTE_VAL       = 4'h1;
    localparam logic [3:0] CIPHER_ROUND_ON_VAL   = 4'h2;
    localparam logic [3:0] BASE_VERSION_VAL      = 4'h1;
    localparam logic [3:0] CRYPTO_OFF_VAL        = 4'h0;
    localparam logic [63:0] RESERVED_MASK        = 64'hf00f_00f0_ff00_ff00;

    // ------------------------------------------------------------
    // access encoding
    // ------------------------------------------------------------
    localparam logic [1:0] ENC_OP0               = 2'h3;
    localparam logic [2:0] ENC_OP1               = 3'h0;
    localparam logic [3:0] ENC_CRN               = 4'h0;
    localparam logic [3:0] ENC_CRM               = 4'h4;
    localparam logic [2:0] ENC_OP2               = 3'h4;

    // ------------------------------------------------------------
    // privilege levels and trap syndrome
    // ------------------------------------------------------------
    localparam logic [1:0] EL_USER               = 2'h0;
    localparam logic [1:0] EL_KERNEL             = 2'h1;
    localparam logic [1:0] EL_HYP                = 2'h2;
    localparam logic [1:0] EL_MONITOR            = 2'h3;
    localparam logic [5:0] TRAP_CLASS_SYSREG     = 6'h18;
    localparam logic [5:0] TRAP_CLASS_NONE       = 6'h00;

    typedef enum logic [1:0] {
        ANS_NONE,
        ANS_DATA,
        ANS_TRAP,
        ANS_WRITE_IGNORED
    } vfid_answer_t;

    function automatic logic vfid_enc_hit(
        input logic [1:0] op0,
        input logic [2:0] op1,
        input logic [3:0] crn,
        input logic [3:0] crm,
        input logic [2:0] op2
    );
        vfid_enc_hit = (op0 == ENC_OP0) && (op1 == ENC_OP1) &&
                       (crn == ENC_CRN) && (crm == ENC_CRM) &&
                       (op2 == ENC_OP2);
    endfunction

endpackage

/* File: rtl/vfid_val_if.sv */
// Purpose: carries crypto configuration to the value builder and back
// Assumes: purely combinational link inside the block
// Notes:   none
`timescale 1ns/1ns
interface vfid_val_if;
    logic        crypto_on;
    logic [63:0] value;

    modport builder (input crypto_on, output value);
    modport user    (output crypto_on, input value);
endinterface

/* File: rtl/vfid_value.sv */
// Purpose: builds the constant identification word
// Assumes: crypto_on is a stable configuration level
// Notes:   reserved ranges are left at zero
`timescale 1ns/1ns
module vfid_value
    import vfid_pkg::*;
(
    // value link
    vfid_val_if.builder val
);

    // ------------------------------------------------------------
    // assembly
    // ------------------------------------------------------------
    logic [63:0] word;
    logic [3:0]  cipher_f;
    logic [3:0]  hash_f;
    logic [3:0]  round_f;

    always_comb
    begin
        cipher_f = val.crypto_on ? BLOCK_CIPHER_ON_VAL : CRYPTO_OFF_VAL;
        hash_f   = val.crypto_on ? KECCAK_HASH_ON_VAL  : CRYPTO_OFF_VAL;
        round_f  = val.crypto_on ? CIPHER_ROUND_ON_VAL : CRYPTO_OFF_VAL;
        word     = 64'h0;
        word[DOUBLE_MATMUL_LSB   +: FIELD_W] = DOUBLE_MATMUL_VAL;
        word[SINGLE_MATMUL_LSB   +: FIELD_W] = SINGLE_MATMUL_VAL;
        word[BYTE_INT_MATMUL_LSB +: FIELD_W] = BYTE_INT_MATMUL_VAL;
        word[BLOCK_CIPHER_LSB    +: FIELD_W] = cipher_f;
        word[KECCAK_HASH_LSB     +: FIELD_W] = hash_f;
        word[BRAIN_FLOAT_LSB     +: FIELD_W] = BRAIN_FLOAT_VAL;
        word[BIT_PERMUTE_LSB     +: FIELD_W] = BIT_PERMUTE_VAL;
        word[CIPHER_ROUND_LSB    +: FIELD_W] = round_f;
        word[BASE_VERSION_LSB    +: FIELD_W] = BASE_VERSION_VAL;
        // belt and braces: force reserved ranges low
        word = word & ~RESERVED_MASK;
    end

    assign val.value = word;

endmodule

/* File: rtl/vfid_top.sv */
// Purpose: vector feature identification register with access checks
// Assumes: one read or write request per cycle, inputs synchronous
// Notes:   answer comes one cycle after the request
//
// Notes on behaviour
// - double-precision matrix multiply field [59:56] reads zero.
// - single-precision matrix multiply field [55:52] reads zero.
// - byte integer matrix multiply field [47:44] reads one.
// - block cipher field [43:40] reads one only with crypto on, else zero.
// - keccak hash field [35:32] reads one only with crypto on, else zero.
// - brain-float field [23:20] reads one.
// - bit permute field [19:16] reads one.
// - cipher round field [7:4] reads two with crypto on, else zero.
// - base vector version field [3:0] reads one.
// - reserved ranges always read zero.
// - selected by encoding op0 3, op1 0, crn 0, crm 4, op2 4.
// - user read traps class 0x18, to hypervisor if enabled and routed, else kernel.
// - kernel read traps to hypervisor when enabled and id trap set.
`timescale 1ns/1ns
module vfid_top
    import vfid_pkg::*;
#(
    parameter bit CRYPTO_IMPLEMENTED = 1'b1
)
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,

    // access request
    input  wire logic        rd_req_i,
    input  wire logic        wr_req_i,
    input  wire logic [1:0]  op0_i,
    input  wire logic [2:0]  op1_i,
    input  wire logic [3:0]  crn_i,
    input  wire logic [3:0]  crm_i,
    input  wire logic [2:0]  op2_i,
    input  wire logic [1:0]  el_i,

    // trap controls
    input  wire logic        hyp_enabled_i,
    input  wire logic        hyp_id_read_trap_i,
    input  wire logic        hyp_trap_general_route_i,

    // configuration
    input  wire logic        crypto_enable_i,

    // answer
    output logic             sel_o,
    output logic             ack_o,
    output logic [63:0]      data_o,
    output logic             trap_o,
    output logic [1:0]       trap_el_o,
    output logic [5:0]       trap_class_o,
    output logic             wr_ignored_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        vfid_answer_t answer;
        logic [63:0]  data;
        logic [1:0]   trap_el;
        logic [5:0]   trap_class;
    } vfid_state_t;

    vfid_state_t state_reg;
    vfid_state_t state_next;

    // ------------------------------------------------------------
    // value builder
    // ------------------------------------------------------------
    vfid_val_if val ();

    // crypto off when not built in, regardless of the enable input
    assign val.crypto_on = CRYPTO_IMPLEMENTED
                           & crypto_enable_i;

    vfid_value u_value (
        .val (val)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic hit;
    logic rd_hit;
    logic wr_hit;
    logic trap_now;
    logic [1:0] trap_tgt;

    assign hit    = vfid_enc_hit(op0_i, op1_i, crn_i, crm_i, op2_i);
    assign rd_hit = rd_req_i & hit;
    // a read and a write together: the read is served, the write dropped
    assign wr_hit = wr_req_i & ~rd_req_i & hit;

    always_comb
    begin
        trap_now = 1'b0;
        trap_tgt = EL_KERNEL;
        case (el_i)
            EL_USER:
            begin
                trap_now = 1'b1;
                trap_tgt = (hyp_enabled_i && hyp_trap_general_route_i)
                           ? EL_HYP : EL_KERNEL;
            end
            EL_KERNEL:
            begin
                trap_now = hyp_enabled_i & hyp_id_read_trap_i;
                trap_tgt = EL_HYP;
            end
            EL_HYP,
            EL_MONITOR:
            begin
                trap_now = 1'b0;
                trap_tgt = EL_KERNEL;
            end
            default:
            begin
                trap_now = 1'b0;
                trap_tgt = EL_KERNEL;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next            = state_reg;
        state_next.answer     = ANS_NONE;
        state_next.data       = 64'h0;
        state_next.trap_el    = EL_USER;
        state_next.trap_class = TRAP_CLASS_NONE;
        if (rd_hit)
        begin
            if (trap_now)
            begin
                state_next.answer     = ANS_TRAP;
                state_next.trap_el    = trap_tgt;
                state_next.trap_class = TRAP_CLASS_SYSREG;
            end
            else
            begin
                state_next.answer = ANS_DATA;
                state_next.data   = val.value;
            end
        end
        else if (wr_hit)
        begin
            // no storage exists, so nothing can change
            state_next.answer = ANS_WRITE_IGNORED;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // only the answer pipeline resets; the identification value is
    // never stored, so reset cannot alter it
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= '{answer:     ANS_NONE,
                           data:       64'h0,
                           trap_el:    EL_USER,
                           trap_class: TRAP_CLASS_NONE};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // all flags decode from one registered code, so two kinds of
    // answer can never show in the same cycle
    always_comb
    begin
        ack_o        = 1'b0;
        trap_o       = 1'b0;
        wr_ignored_o = 1'b0;
        case (state_reg.answer)
            ANS_NONE:
            begin
                ack_o = 1'b0;
            end
            ANS_DATA:
            begin
                ack_o = 1'b1;
            end
            ANS_TRAP:
            begin
                ack_o  = 1'b1;
                trap_o = 1'b1;
            end
            ANS_WRITE_IGNORED:
            begin
                ack_o        = 1'b1;
                wr_ignored_o = 1'b1;
            end
            default:
            begin
                ack_o = 1'b0;
            end
        endcase
    end

    assign sel_o        = hit;
    assign data_o       = state_reg.data;
    assign trap_el_o    = state_reg.trap_el;
    assign trap_class_o = state_reg.trap_class;

endmodule

/* File: testbench/vfid_chk.sv */
// Purpose: port checks for the vector feature id register
// Assumes: one clock, async active-low reset
// Notes:   read checks qualify on an encoding hit
`timescale 1ns/1ns
module vfid_chk
    import vfid_pkg::*;
#(
    parameter bit CRYPTO_IMPLEMENTED = 1'b1
)
(
    // clock, reset, request
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        rd_req_i,
    input wire logic        wr_req_i,
    input wire logic [1:0]  op0_i,
    input wire logic [2:0]  op1_i,
    input wire logic [3:0]  crn_i,
    input wire logic [3:0]  crm_i,
    input wire logic [2:0]  op2_i,
    input wire logic [1:0]  el_i,
    // controls
    input wire logic        hyp_enabled_i,
    input wire logic        hyp_id_read_trap_i,
    input wire logic        hyp_trap_general_route_i,
    input wire logic        crypto_enable_i,
    // answer
    input wire logic        sel_o,
    input wire logic        ack_o,
    input wire logic [63:0] data_o,
    input wire logic        trap_o,
    input wire logic [1:0]  trap_el_o,
    input wire logic [5:0]  trap_class_o,
    input wire logic        wr_ignored_o
);
    logic hit;
    logic rq;
    logic cr;
    assign hit = op0_i == 2'h3 && op1_i == 3'h0 && crn_i == 4'h0
                 && crm_i == 4'h4 && op2_i == 3'h4;
    assign rq = rd_req_i && hit;
    assign cr = crypto_enable_i && CRYPTO_IMPLEMENTED;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sel_match_a: assert property (sel_o == hit)
        else $error("select does not follow encoding");
    ack_follow_a: assert property
        ((rd_req_i || wr_req_i) && hit |=> ack_o)
        else $error("request not answered");
    no_stray_a: assert property
        (!((rd_req_i || wr_req_i) && hit) |=> !ack_o)
        else $error("answer without request");
    user_trap_a: assert property (rq && el_i == 2'h0 |=> trap_o
        && trap_class_o == 6'h18 && trap_el_o == (($past(hyp_enabled_i)
        && $past(hyp_trap_general_route_i)) ? 2'h2 : 2'h1))
        else $error("user read trap wrong");
    kern_trap_a: assert property (rq && el_i == 2'h1 |=> trap_o ==
        ($past(hyp_enabled_i) && $past(hyp_id_read_trap_i)))
        else $error("kernel read trap wrong");
    reserved_zero_a: assert property
        ((data_o & 64'hffff_00f0_ff00_ff00) == 64'h0)
        else $error("reserved or absent field set");
    fixed_fields_a: assert property
        (rq && el_i[1] |=> data_o[47:44] == 4'h1
        && data_o[23:16] == 8'h11 && data_o[3:0] == 4'h1)
        else $error("fixed field wrong");
    crypto_on_a: assert property (rq && el_i[1] && cr |=>
        data_o[43:32] == 12'h101 && data_o[7:4] == 4'h2)
        else $error("crypto fields wrong when on");
    crypto_off_a: assert property (rq && el_i[1] && !cr |=>
        data_o[43:32] == 12'h0 && data_o[7:4] == 4'h0)
        else $error("crypto fields wrong when off");
    write_ign_a: assert property (wr_req_i && !rd_req_i && hit |=>
        wr_ignored_o && !trap_o && data_o == 64'h0)
        else $error("write answer wrong");
    cover property (rq && el_i[1] ##1 ack_o);
    cover property (rq ##1 trap_o);
    cover property (wr_req_i && hit ##1 wr_ignored_o);
endmodule

bind vfid_top vfid_chk #(.CRYPTO_IMPLEMENTED(CRYPTO_IMPLEMENTED)) vfid_chk_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req_i),
    .wr_req_i(wr_req_i), .op0_i(op0_i), .op1_i(op1_i), .crn_i(crn_i),
    .crm_i(crm_i), .op2_i(op2_i), .el_i(el_i),
    .hyp_enabled_i(hyp_enabled_i), .hyp_id_read_trap_i(hyp_id_read_trap_i),
    .hyp_trap_general_route_i(hyp_trap_general_route_i),
    .crypto_enable_i(crypto_enable_i), .sel_o(sel_o), .ack_o(ack_o),
    .data_o(data_o), .trap_o(trap_o), .trap_el_o(trap_el_o),
    .trap_class_o(trap_class_o), .wr_ignored_o(wr_ignored_o));

/* File: testbench/tb_top.sv */
// Purpose: scenario bench for the vector feature id register
// Assumes: inputs change on the falling edge
// Notes:   crypto-absent build needs its own elaboration
`timescale 1ns/1ns
module tb_top;
    localparam logic [63:0] V_ON  = 64'h0000_1101_0011_0021;
    localparam logic [63:0] V_OFF = 64'h0000_1000_0011_0001;
    logic        clk = 0, rst_n = 0, rd = 0, wr = 0;
    logic [1:0]  op0 = 2'h3, el = 2'h2, tel;
    logic [2:0]  op1 = 3'h0, op2 = 3'h4;
    logic [3:0]  crn = 4'h0, crm = 4'h4;
    logic        hen = 0, htrap = 0, hroute = 0, cen = 1;
    logic        sel, ack, trap, wign;
    logic [5:0]  tcls;
    logic [63:0] data;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;

    vfid_top vfid_top_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .rd_req_i(rd),
        .wr_req_i(wr), .op0_i(op0), .op1_i(op1), .crn_i(crn), .crm_i(crm),
        .op2_i(op2), .el_i(el), .hyp_enabled_i(hen),
        .hyp_id_read_trap_i(htrap), .hyp_trap_general_route_i(hroute),
        .crypto_enable_i(cen), .sel_o(sel), .ack_o(ack), .data_o(data),
        .trap_o(trap), .trap_el_o(tel), .trap_class_o(tcls),
        .wr_ignored_o(wign));

    always #50 clk = ~clk;
    // a hang is cut here; the whole run needs about 70 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [63:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic access(input logic r, w, input logic [1:0] e);
        @(negedge clk);
        rd = r;
        wr = w;
        el = e;
        @(negedge clk);
        rd = 0;
        wr = 0;
    endtask

    task automatic t_read;
        cen = 1;
        access(1, 0, 2'h2);
        chk("ack", 1, ack);
        chk("data on", V_ON, data);
        cen = 0;
        access(1, 0, 2'h3);
        chk("data off", V_OFF, data);
        chk("trap", 0, trap);
        cen = 1;
    endtask

    task automatic t_trap;
        logic t;
        logic [1:0] te;
        for (int i = 0; i < 16; i++)
        begin
            {htrap, hroute, hen} = i[2:0];
            t = i[3] ? hen & htrap : 1'b1;
            te = !t ? 2'h0 : (i[3] ? 2'h2 : ((hen & hroute) ? 2'h2 : 2'h1));
            access(1, 0, {1'b0, i[3]});
            chk("trap", t, trap);
            chk("trap el", te, tel);
            chk("class", t ? 6'h18 : 6'h0, tcls);
            chk("data", t ? 64'h0 : V_ON, data);
        end
        {htrap, hroute, hen} = 3'h0;
    endtask

    task automatic t_enc;
        for (int f = 0; f < 5; f++)
        begin
            @(negedge clk);
            case (f)
                0: op0 = 2'h2;
                1: op1 = 3'h1;
                2: crn = 4'h1;
                3: crm = 4'h5;
                default: op2 = 3'h3;
            endcase
            #1 chk("sel off", 0, sel);
            access(1, 1, 2'h2);
            chk("ack off", 0, ack);
            {op0, op1, crn, crm, op2} = {2'h3, 3'h0, 4'h0, 4'h4, 3'h4};
        end
        #1 chk("sel on", 1, sel);
    endtask

    task automatic t_write;
        access(0, 1, 2'h0);
        chk("wr ack", 1, ack);
        chk("wr ign", 1, wign);
        chk("wr data", 0, data);
        chk("wr trap", 0, trap);
        access(1, 1, 2'h2);
        chk("rw data", V_ON, data);
        chk("rw ign", 0, wign);
        // reset lands while the read answer still stands
        rst_n = 0;
        #1 chk("rst ack", 0, ack);
        chk("rst data", 0, data);
        repeat (2) @(negedge clk);
        rst_n = 1;
        access(1, 0, 2'h2);
        chk("after reset", V_ON, data);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1;
        t_read();
        t_trap();
        t_enc();
        t_write();
        results();
    end
endmodule
